// File: hw/pwr_pkg.sv
// Functional notes
// - Claim system accesses from 0x90000000 through 0xBFFFFFFF as PCI space targets.
// - Hold 0x60000000 to 0x6FFFFFFF reserved; claim it only when expansion is enabled.
// - Select control window, I/O window and memory window inside the claimed range.
// - The host generates and drives the PCI bus clock to the cards.
// - Route slot B pins and slot A pins 0, 1 and 3 onto outputs 0 to 3 per fixed table; slot A pin 2 is not routed.
// - Outputs 4 to 7 carry PCI Express virtual INTA to INTD one each.
// - No DMA request or acknowledge lines; a separate DMA controller moves data.
`default_nettype none
package pwr_pkg;
   localparam logic [31:0] PCI_SPACE_LO = 32'h9000_0000;
   localparam logic [31:0] PCI_SPACE_HI = 32'hbfff_ffff;
   localparam logic [31:0] EXP_SPACE_LO = 32'h6000_0000;
   localparam logic [31:0] EXP_SPACE_HI = 32'h6fff_ffff;
   localparam logic [31:0] CTRL_WIN_LO = 32'h9004_0000;
   localparam logic [31:0] CTRL_WIN_HI = 32'h9004_ffff;
   localparam logic [31:0] IO_WIN_LO = 32'h9005_0000;
   localparam logic [31:0] IO_WIN_HI = 32'h9005_ffff;
   localparam logic [31:0] MEM_WIN_LO = 32'ha000_0000;
   localparam logic [31:0] MEM_WIN_HI = 32'hbfff_ffff;
   localparam logic [31:0] EXP_WIN_LO = 32'h6000_0000;
   localparam int SYS_CLK_MHZ = 40;
   localparam int PCI_CLK_MHZ = 10;
   localparam int PCI_CLK_HALF = SYS_CLK_MHZ / (2 * PCI_CLK_MHZ);
   localparam logic [3:0] IRQ_RESET = 4'hf;
   localparam logic [7:0] OUT_RESET = 8'hff;
   typedef enum logic [2:0]
   {
      WIN_NONE = 3'h0,
      WIN_PCI_OTHER = 3'h1,
      WIN_CTRL = 3'h3,
      WIN_IO = 3'h2,
      WIN_MEM = 3'h6,
      WIN_EXP = 3'h7
   } pwr_win_t;
   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction
endpackage
`default_nettype wire

// File: hw/pwr_irq_if.sv
`default_nettype none
interface pwr_irq_if;
   logic [3:0] slot_a_n;
   logic [3:0] slot_b_n;
   logic [3:0] pcie_n;
   logic [7:0] routed_n;
   modport router (input slot_a_n, input slot_b_n, input pcie_n, output routed_n);
   modport top (output slot_a_n, output slot_b_n, output pcie_n, input routed_n);
endinterface
`default_nettype wire

// File: hw/pwr_irq_map.sv
`default_nettype none
module pwr_irq_map
(
   pwr_irq_if.router irq
);
   // Active low, so sharing is an AND of the two lines.
   function automatic logic share_n(input logic x_n, input logic y_n);
      share_n = x_n & y_n;
   endfunction
   // Index 0..3 is INTA..INTD.
   assign irq.routed_n[0] = share_n(irq.slot_a_n[3], irq.slot_b_n[2]);
   assign irq.routed_n[1] = share_n(irq.slot_a_n[0], irq.slot_b_n[3]);
   assign irq.routed_n[2] = share_n(irq.slot_a_n[1], irq.slot_b_n[0]);
   assign irq.routed_n[3] = share_n(irq.slot_a_n[3], irq.slot_b_n[1]);
   assign irq.routed_n[7:4] = irq.pcie_n;
endmodule
`default_nettype wire

// File: hw/pwr_router.sv
`default_nettype none
module pwr_router
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic EXP_ENABLE,
   input wire logic ADDR_VALID,
   input wire logic [31:0] ADDR,
   input wire logic [3:0] SLOT_IRQ_A_N,
   input wire logic [3:0] SLOT_IRQ_B_N,
   input wire logic [3:0] PCIE_IRQ_N,
   output logic CLAIM,
   output logic SEL_CTRL,
   output logic SEL_IO,
   output logic SEL_MEM,
   output logic SEL_EXP,
   output logic [27:0] OFFSET,
   output logic PCI_CLK,
   output logic [7:0] ROUTED_IRQ_OUT_N
);
   pwr_irq_if irq ();
   pwr_pkg::pwr_win_t win;

   wire logic in_pci;
   wire logic in_exp;
   wire logic in_ctrl;
   wire logic in_io;
   wire logic in_mem;

   wire logic nxt_claim;
   wire logic nxt_sel_ctrl;
   wire logic nxt_sel_io;
   wire logic nxt_sel_mem;
   wire logic nxt_sel_exp;
   wire logic [27:0] nxt_offset;
   wire logic [7:0] nxt_irq;
   wire logic div_wrap;
   wire logic [3:0] nxt_div;
   wire logic nxt_pci_clk;

   logic claim_ff;
   logic sel_ctrl_ff;
   logic sel_io_ff;
   logic sel_mem_ff;
   logic sel_exp_ff;
   logic [27:0] offset_ff;
   logic [7:0] irq_ff;
   logic pci_clk_ff;
   logic [3:0] div_ff;

   assign irq.slot_a_n = SLOT_IRQ_A_N;
   assign irq.slot_b_n = SLOT_IRQ_B_N;
   assign irq.pcie_n = PCIE_IRQ_N;

   pwr_irq_map u_map
   (
      .irq(irq)
   );

   assign in_pci = pwr_pkg::in_range(ADDR, pwr_pkg::PCI_SPACE_LO, pwr_pkg::PCI_SPACE_HI);
   // The reserved space stays unclaimed unless expansion is switched on.
   assign in_exp = EXP_ENABLE &&
      pwr_pkg::in_range(ADDR, pwr_pkg::EXP_SPACE_LO, pwr_pkg::EXP_SPACE_HI);
   assign in_ctrl =
      pwr_pkg::in_range(ADDR, pwr_pkg::CTRL_WIN_LO, pwr_pkg::CTRL_WIN_HI);
   assign in_io =
      pwr_pkg::in_range(ADDR, pwr_pkg::IO_WIN_LO, pwr_pkg::IO_WIN_HI);
   assign in_mem =
      pwr_pkg::in_range(ADDR, pwr_pkg::MEM_WIN_LO, pwr_pkg::MEM_WIN_HI);

   // One I/O window only; the host has no bus-select bits to share it.
   assign win = !ADDR_VALID ? pwr_pkg::WIN_NONE :
      in_ctrl ? pwr_pkg::WIN_CTRL :
      in_io ? pwr_pkg::WIN_IO :
      in_mem ? pwr_pkg::WIN_MEM :
      in_pci ? pwr_pkg::WIN_PCI_OTHER :
      in_exp ? pwr_pkg::WIN_EXP : pwr_pkg::WIN_NONE;

   // The memory window is wider than the offset port, so its offset keeps only the low
   // 28 bits; a user that needs the full span must also look at the address itself.
   assign nxt_offset = (win == pwr_pkg::WIN_CTRL) ? 28'(ADDR - pwr_pkg::CTRL_WIN_LO) :
      (win == pwr_pkg::WIN_IO) ? 28'(ADDR - pwr_pkg::IO_WIN_LO) :
      (win == pwr_pkg::WIN_MEM) ? 28'(ADDR - pwr_pkg::MEM_WIN_LO) :
      (win == pwr_pkg::WIN_EXP) ? 28'(ADDR - pwr_pkg::EXP_WIN_LO) : 28'h0;

   assign nxt_claim = (win != pwr_pkg::WIN_NONE);
   assign nxt_sel_ctrl = (win == pwr_pkg::WIN_CTRL);
   assign nxt_sel_io = (win == pwr_pkg::WIN_IO);
   assign nxt_sel_mem = (win == pwr_pkg::WIN_MEM);
   assign nxt_sel_exp = (win == pwr_pkg::WIN_EXP);
   // Registered so the routed lines never glitch while two slot pins change.
   assign nxt_irq = irq.routed_n;

   // The host makes the card clock by dividing its own clock.
   assign div_wrap = (div_ff == 4'(pwr_pkg::PCI_CLK_HALF - 1));
   assign nxt_div = div_wrap ? 4'h0 : div_ff + 4'h1;
   assign nxt_pci_clk = div_wrap ? ~pci_clk_ff : pci_clk_ff;

   // A low CE also stops the card clock, so the cards never see an edge while the
   // host is frozen; the price is that the card clock is not free running.
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         claim_ff <= 1'b0;
      end
      else if (CE)
      begin
         claim_ff <= nxt_claim;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sel_ctrl_ff <= 1'b0;
      end
      else if (CE)
      begin
         sel_ctrl_ff <= nxt_sel_ctrl;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sel_io_ff <= 1'b0;
      end
      else if (CE)
      begin
         sel_io_ff <= nxt_sel_io;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sel_mem_ff <= 1'b0;
      end
      else if (CE)
      begin
         sel_mem_ff <= nxt_sel_mem;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sel_exp_ff <= 1'b0;
      end
      else if (CE)
      begin
         sel_exp_ff <= nxt_sel_exp;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         offset_ff <= 28'h0;
      end
      else if (CE)
      begin
         offset_ff <= nxt_offset;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         irq_ff <= pwr_pkg::OUT_RESET;
      end
      else if (CE)
      begin
         irq_ff <= nxt_irq;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         div_ff <= 4'h0;
      end
      else if (CE)
      begin
         div_ff <= nxt_div;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         pci_clk_ff <= 1'b0;
      end
      else if (CE)
      begin
         pci_clk_ff <= nxt_pci_clk;
      end
   end

   // No DMA handshake ports exist on this block by design.
   assign CLAIM = claim_ff;
   assign SEL_CTRL = sel_ctrl_ff;
   assign SEL_IO = sel_io_ff;
   assign SEL_MEM = sel_mem_ff;
   assign SEL_EXP = sel_exp_ff;
   assign OFFSET = offset_ff;
   assign PCI_CLK = pci_clk_ff;
   assign ROUTED_IRQ_OUT_N = irq_ff;
endmodule
`default_nettype wire

// File: testbench/pwr_router_assertions.sv
`default_nettype none
module pwr_router_assertions
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic EXP_ENABLE,
   input wire logic ADDR_VALID,
   input wire logic [31:0] ADDR,
   input wire logic [3:0] SLOT_IRQ_A_N,
   input wire logic [3:0] SLOT_IRQ_B_N,
   input wire logic [3:0] PCIE_IRQ_N,
   input wire logic CLAIM,
   input wire logic SEL_CTRL,
   input wire logic SEL_IO,
   input wire logic SEL_MEM,
   input wire logic SEL_EXP,
   input wire logic PCI_CLK,
   input wire logic [27:0] OFFSET,
   input wire logic [7:0] ROUTED_IRQ_OUT_N
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   wire logic v = CE && ADDR_VALID;
   wire logic pci = ADDR >= 32'h9000_0000 && ADDR <= 32'hbfff_ffff;
   wire logic rsv = ADDR[31:28] == 4'h6;
   claim_pci_a: assert property ($past(v && pci) |-> CLAIM)
      else $error("PCI access not claimed");
   reserve_gate_a: assert property ($past(v && rsv) |-> CLAIM == $past(EXP_ENABLE))
      else $error("Reserved space gating wrong");
   io_window_a: assert property ($past(v && ADDR[31:16] == 16'h9005) |-> SEL_IO
      && OFFSET == {12'h0, $past(ADDR[15:0])}) else $error("I/O window decode wrong");
   mem_window_a: assert property ($past(v && pci && ADDR[29]) |-> SEL_MEM && !SEL_IO)
      else $error("Memory window decode wrong");
   no_claim_a: assert property ($past(CE) && !$past(v && (pci || rsv)) |-> !CLAIM)
      else $error("Foreign address claimed");
   slot_route_a: assert property ($past(CE) |-> ROUTED_IRQ_OUT_N[3:0] == $past({
      SLOT_IRQ_A_N[3] & SLOT_IRQ_B_N[1], SLOT_IRQ_A_N[1] & SLOT_IRQ_B_N[0],
      SLOT_IRQ_A_N[0] & SLOT_IRQ_B_N[3], SLOT_IRQ_A_N[3] & SLOT_IRQ_B_N[2]}))
      else $error("Slot interrupt routing wrong");
   pcie_route_a: assert property ($past(CE) |-> ROUTED_IRQ_OUT_N[7:4] == $past(PCIE_IRQ_N))
      else $error("Virtual interrupt routing wrong");
   clock_div_a: assert property ($rose(PCI_CLK) && CE ##1 CE |-> PCI_CLK ##1 !PCI_CLK)
      else $error("Card clock shape wrong");
endmodule
bind pwr_router pwr_router_assertions pwr_router_assertions_inst
(
   .CLOCK(CLOCK),
   .RESETN(RESETN),
   .CE(CE),
   .EXP_ENABLE(EXP_ENABLE),
   .ADDR_VALID(ADDR_VALID),
   .ADDR(ADDR),
   .SLOT_IRQ_A_N(SLOT_IRQ_A_N),
   .SLOT_IRQ_B_N(SLOT_IRQ_B_N),
   .PCIE_IRQ_N(PCIE_IRQ_N),
   .CLAIM(CLAIM),
   .SEL_CTRL(SEL_CTRL),
   .SEL_IO(SEL_IO),
   .SEL_MEM(SEL_MEM),
   .SEL_EXP(SEL_EXP),
   .PCI_CLK(PCI_CLK),
   .OFFSET(OFFSET),
   .ROUTED_IRQ_OUT_N(ROUTED_IRQ_OUT_N)
);
`default_nettype wire

// File: testbench/pwr_card_model.sv
`default_nettype none
module pwr_card_model
(
   input wire logic [11:0] IRQ_REQ,
   output logic [3:0] SLOT_IRQ_A_N,
   output logic [3:0] SLOT_IRQ_B_N,
   output logic [3:0] PCIE_IRQ_N
);
   timeunit 1ns;
   timeprecision 100ps;
   // Lines are pulled up, so a card that lets go shows the inactive high level.
   assign {PCIE_IRQ_N, SLOT_IRQ_B_N, SLOT_IRQ_A_N} = ~IRQ_REQ;
endmodule
`default_nettype wire

// File: testbench/pwr_router_test.sv
`default_nettype none
module pwr_router_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLOCK = 0, RESETN = 0, CE = 0, EXP_ENABLE = 0, ADDR_VALID = 0;
   logic [31:0] ADDR = 0;
   logic [11:0] IRQ_REQ = 0;
   logic CLAIM, SEL_CTRL, SEL_IO, SEL_MEM, SEL_EXP, PCI_CLK;
   logic [27:0] OFFSET;
   logic [7:0] ROUTED_IRQ_OUT_N;
   logic [3:0] SLOT_IRQ_A_N, SLOT_IRQ_B_N, PCIE_IRQ_N;
   logic [41:0] q[$], n;
   int miscompares = 0, samples_checked = 0, cyc = 0, ce_cnt = 0;
   // All I/O traffic targets the single window that one bus owns at a time.
   logic [31:0] tbl[12] = '{32'h8fff_ffff, 32'h9000_0000, 32'h9004_0010, 32'h9005_0010,
      32'h9005_ffff, 32'ha000_0000, 32'hbfff_ffff, 32'hc000_0000, 32'h5fff_ffff,
      32'h6000_0000, 32'h6fff_ffff, 32'h7000_0000};
   pwr_router pwr_router_inst
   (
      .CLOCK(CLOCK),
      .RESETN(RESETN),
      .CE(CE),
      .EXP_ENABLE(EXP_ENABLE),
      .ADDR_VALID(ADDR_VALID),
      .ADDR(ADDR),
      .SLOT_IRQ_A_N(SLOT_IRQ_A_N),
      .SLOT_IRQ_B_N(SLOT_IRQ_B_N),
      .PCIE_IRQ_N(PCIE_IRQ_N),
      .CLAIM(CLAIM),
      .SEL_CTRL(SEL_CTRL),
      .SEL_IO(SEL_IO),
      .SEL_MEM(SEL_MEM),
      .SEL_EXP(SEL_EXP),
      .OFFSET(OFFSET),
      .PCI_CLK(PCI_CLK),
      .ROUTED_IRQ_OUT_N(ROUTED_IRQ_OUT_N)
   );
   pwr_card_model pwr_card_model_inst
   (
      .IRQ_REQ(IRQ_REQ),
      .SLOT_IRQ_A_N(SLOT_IRQ_A_N),
      .SLOT_IRQ_B_N(SLOT_IRQ_B_N),
      .PCIE_IRQ_N(PCIE_IRQ_N)
   );
   always #12.5 CLOCK = ~CLOCK;
   task automatic chk(input logic [41:0] s, input logic [41:0] e);
      samples_checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %0t outputs %h expected %h", $time, s, e);
      end
   endtask
   task automatic drive(input logic [31:0] a, input logic v, x, c, input logic [11:0] r);
      logic p, ct, io, m, e;
      @(negedge CLOCK);
      {ADDR, ADDR_VALID, EXP_ENABLE, CE, IRQ_REQ} = {a, v, x, c, r};
      p = a >= 32'h9000_0000 && a <= 32'hbfff_ffff;
      e = a[31:28] == 4'h6 && x;
      ct = p && a[31:16] == 16'h9004;
      io = p && a[31:16] == 16'h9005;
      m = p && a >= 32'ha000_0000;
      if (c)
      begin
         ce_cnt++;
         // The card clock flips on every second enabled edge: two high, two low.
         // Window offsets keep only the low 28 bits, memory window included.
         q.push_back({ce_cnt[1], v && (p || e), v && ct, v && io, v && m, v && e,
            ~{r[11:8], r[3] | r[5], r[1] | r[4], r[0] | r[7], r[3] | r[6]},
            !v ? 28'h0 : (ct || io) ? {12'h0, a[15:0]} : (e || m) ? a[27:0] : 28'h0});
      end
   endtask
   task automatic print_verdict;
      $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge CLOCK)
   begin
      if (++cyc == 5000)
      begin
         miscompares++;
         print_verdict;
      end
      else if (q.size() > 0)
      begin
         #1 n = q.pop_front();
         chk({PCI_CLK, CLAIM, SEL_CTRL, SEL_IO, SEL_MEM, SEL_EXP,
            ROUTED_IRQ_OUT_N, OFFSET}, n);
      end
   end
   initial
   begin
      void'($urandom(32'h2c80));
      repeat (16) @(posedge CLOCK);
      @(negedge CLOCK) RESETN = 1;
      foreach (tbl[i])
         for (int e = 0; e < 2; e++)
            drive(tbl[i], 1'b1, e[0], 1'b1, 12'h0);
      $display("Address boundary test done");
      for (int i = 0; i < 12; i++)
         drive(32'h0, 1'b0, 1'b0, 1'b1, 12'h1 << i);
      $display("Interrupt routing test done");
      repeat (2000)
         drive({4'($urandom % 8 + 5), 28'($urandom)}, $urandom % 8 != 0, 1'($urandom),
            $urandom % 8 != 0, 12'($urandom));
      drive(32'h0, 1'b0, 1'b0, 1'b1, 12'h0);
      $display("Random traffic test done");
      repeat (3) @(posedge CLOCK);
      print_verdict;
   end
endmodule
`default_nettype wire
